// >>> design/channel_pwm_control.sv
// module: serial channel words, clock supervision and four pwm channels
`default_nettype none
// Function
// R01 - pwm frequency and switching timing come from the external clock input
// R02 - on clock failure, too slow or too fast, outputs run at 100% duty
// R03 - four output channels, each governed by its own channel control word
// R04 - 16-bit word: address, keep-alive, phase, on bit, 8-bit duty
// R05 - switching speed follows each channel's prescale divider
// R06 - host keeps duty within the usable range for each divider
// R07 - rising and falling delays matched so duty error stays within one lsb
// R08 - closed loop measures actual duty and corrects timing
// R09 - off, full duty, phase, prescale act at frame end; others next period
// R10 - prescale 00 divides 4, 01 divides 2, 1x divides 1; 8-bit resolution
// R11 - on bits also writable through a separate output control word
// R12 - pwm suspended in fail mode or when the external clock has failed
// R13 - 8-bit period counter on divided clock; output active below duty
module channel_pwm_control
#(
  parameter int unsigned CHANNELS    = 4,
  parameter int unsigned GAP_MAX_CYC = pwm_pkg::GAP_MAX_CYC,
  parameter int unsigned GAP_MIN_CYC = pwm_pkg::GAP_MIN_CYC
)
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                frame_select_low_i,
  input  wire logic                sclk_i,
  input  wire logic                si_i,
  input  wire logic                pwm_clk_i,
  input  wire logic                fail_mode_i,
  input  wire logic [CHANNELS-1:0] sense_i,
  output logic      [CHANNELS-1:0] power_output_o,
  output logic      [CHANNELS-1:0] slew_fast_o,
  output logic                     clock_fail_o,
  output logic                     keepalive_bit_o
);
  localparam int unsigned NPIN = 4 + CHANNELS;

  // refuse settings the fixed fields and counters cannot serve
  if (CHANNELS < 1 || CHANNELS > 4)
    $error("CHANNELS must be 1..4");
  if (GAP_MAX_CYC >= (1 << pwm_pkg::GAP_W) || GAP_MIN_CYC < 1 || GAP_MIN_CYC >= GAP_MAX_CYC)
    $error("clock supervision window out of range");

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] flt_q;
  logic [NPIN-1:0] flt_prev_q;

  assign pins = {sense_i, pwm_clk_i, si_i, sclk_i, frame_select_low_i};

  // three stages per pin; a value counts once stages two and three agree
  genvar gi;
  for (gi = 0; gi < NPIN; gi++)
  begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        s1_q[gi]       <= gi == 0;  // frame select idles high
        s2_q[gi]       <= gi == 0;
        s3_q[gi]       <= gi == 0;
        flt_q[gi]      <= gi == 0;
        flt_prev_q[gi] <= gi == 0;
      end
      else
      begin
        s1_q[gi]       <= pins[gi];
        s2_q[gi]       <= s1_q[gi];
        s3_q[gi]       <= s2_q[gi];
        if (s2_q[gi] == s3_q[gi])
          flt_q[gi]    <= s3_q[gi];
        flt_prev_q[gi] <= flt_q[gi];
      end
    end
  end

  wire logic csb_rise  =  flt_q[0] & ~flt_prev_q[0];
  wire logic csb_fall  = ~flt_q[0] &  flt_prev_q[0];
  wire logic sclk_fall = ~flt_q[1] &  flt_prev_q[1];
  wire logic si_val    =  flt_q[2];
  wire logic pclk_rise =  flt_q[3] & ~flt_prev_q[3];
  wire logic [CHANNELS-1:0] sense_val = flt_q[NPIN-1:4];

  // ---------------------------------------------------------------
  // serial frame receiver
  // ---------------------------------------------------------------
  logic [15:0] shift_q;
  logic [4:0]  bits_q;

  // data is taken on the falling sclk edge; extra bits saturate so long frames are dropped
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_q <= 16'h0000;
      bits_q  <= 5'h00;
    end
    else if (csb_fall)
      bits_q  <= 5'h00;
    else if (sclk_fall && !flt_q[0])
    begin
      shift_q <= {shift_q[14:0], si_val};
      if (bits_q != 5'h1F)
        bits_q <= bits_q + 5'h01;
    end
  end

  wire logic       commit   = csb_rise & (bits_q == pwm_pkg::FRAME_BITS);
  wire logic [3:0] addr     = shift_q[pwm_pkg::ADDR_MSB:pwm_pkg::ADDR_LSB];               // [R04]
  wire logic       wr_chan  = commit & (addr >= pwm_pkg::ADDR_CH_FIRST) & (addr <= pwm_pkg::ADDR_CH_LAST);
  wire logic       wr_outc  = commit & (addr == pwm_pkg::ADDR_OUT_CTRL);
  wire logic       wr_prs   = commit & (addr == pwm_pkg::ADDR_PRESCALE);
  wire logic [3:0] chan_idx = addr - pwm_pkg::ADDR_CH_FIRST;

  // ---------------------------------------------------------------
  // channel settings
  // ---------------------------------------------------------------
  logic [7:0] duty_q  [CHANNELS];
  logic [1:0] phase_q [CHANNELS];
  logic [1:0] prs_q   [CHANNELS];
  logic [CHANNELS-1:0] on_q;
  logic keep_q;
  logic apply_q;

  // keep-alive and the commit pulse for the channels
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      keep_q  <= 1'b0;
      apply_q <= 1'b0;
    end
    else
    begin
      apply_q <= commit;
      if (wr_chan)
        keep_q <= shift_q[pwm_pkg::KEEPALIVE_B];                                          // [R04]
    end
  end

  // one settings slot per channel, written from its own word or shared words
  for (gi = 0; gi < CHANNELS; gi++)
  begin : g_regs
    wire logic hit = wr_chan & (chan_idx == 4'(gi));                                    // [R03]
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        duty_q[gi]  <= 8'h00;
        phase_q[gi] <= 2'h0;
        prs_q[gi]   <= 2'h0;
        on_q[gi]    <= 1'b0;
      end
      else
      begin
        if (hit)
        begin
          duty_q[gi]  <= shift_q[pwm_pkg::DUTY_MSB:pwm_pkg::DUTY_LSB];
          phase_q[gi] <= shift_q[pwm_pkg::PHASE_MSB:pwm_pkg::PHASE_LSB];
          on_q[gi]    <= shift_q[pwm_pkg::ON_B];
        end
        else if (wr_outc)
          on_q[gi]    <= shift_q[gi];                                                   // [R11]
        if (wr_prs)
          prs_q[gi]   <= shift_q[2*gi+1 -: 2];                                          // [R10]
      end
    end
  end

  // ---------------------------------------------------------------
  // external clock supervision
  // ---------------------------------------------------------------
  logic [pwm_pkg::GAP_W-1:0] gap_q;
  logic                      fail_q;

  // count system cycles between clock edges; too long or too short marks a failure
  wire logic gap_long  = gap_q >= pwm_pkg::GAP_W'(GAP_MAX_CYC);
  wire logic gap_short = pclk_rise & (gap_q < pwm_pkg::GAP_W'(GAP_MIN_CYC));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gap_q  <= '0;
      fail_q <= 1'b1;  // no clock seen yet
    end
    else if (pclk_rise)
    begin
      gap_q  <= '0;
      fail_q <= gap_short;                                                              // [R02]
    end
    else if (gap_long)
      fail_q <= 1'b1;                                                                   // [R02]
    else
      gap_q  <= gap_q + 1'b1;
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  for (gi = 0; gi < CHANNELS; gi++)
  begin : g_chan
    pwm_ctrl_if cif ();
    assign cif.duty      = duty_q[gi];
    assign cif.on        = on_q[gi];
    assign cif.phase     = phase_q[gi];
    assign cif.prescale  = prs_q[gi];
    assign cif.tick      = pclk_rise & ~fail_q;                                         // [R01]
    assign cif.apply     = apply_q;
    assign cif.hold_full = fail_q | fail_mode_i;                                        // [R12]
    pwm_channel u_chan
    (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ctl        (cif.chan),
      .sense_i    (sense_val[gi]),
      .out_o      (power_output_o[gi]),
      .slew_fast_o(slew_fast_o[gi])
    );
  end

  assign clock_fail_o    = fail_q;
  assign keepalive_bit_o = keep_q;
endmodule : channel_pwm_control
`default_nettype wire

// >>> design/pwm_pkg.sv
// package: shared constants for the per-channel pwm generator
`default_nettype none
package pwm_pkg;
  // ---------------------------------------------------------------
  // serial control word layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned ADDR_MSB     = 15;
  localparam int unsigned ADDR_LSB     = 12;
  localparam int unsigned KEEPALIVE_B  = 11;
  localparam int unsigned PHASE_MSB    = 10;
  localparam int unsigned PHASE_LSB    = 9;
  localparam int unsigned ON_B         = 8;
  localparam int unsigned DUTY_MSB     = 7;
  localparam int unsigned DUTY_LSB     = 0;
  localparam logic [3:0]  ADDR_CH_FIRST = 4'h2;  // channel words 2..5 drive the four outputs
  localparam logic [3:0]  ADDR_CH_LAST  = 4'h7;  // 6 and 7 decode but have no output here
  localparam logic [3:0]  ADDR_OUT_CTRL = 4'h8;  // duplicate on bits in D3..D0
  localparam logic [3:0]  ADDR_PRESCALE = 4'hC;  // two bits per channel, channel 0 in D1..D0
  localparam logic [4:0]  FRAME_BITS    = 5'h10;
  // ---------------------------------------------------------------
  // pwm field values
  // ---------------------------------------------------------------
  localparam logic [7:0]  DUTY_FULL     = 8'hFF;
  localparam logic [1:0]  PRS_DIV4      = 2'h0;
  localparam logic [1:0]  PRS_DIV2      = 2'h1;
  localparam int unsigned CORR_W        = 4;
  localparam logic [3:0]  CORR_MAX      = 4'h7;
  localparam logic [3:0]  CORR_MIN      = 4'h9;  // -7 in two's complement
  // ---------------------------------------------------------------
  // clock supervision
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ    = 40_000_000;
  localparam int unsigned PWM_CLK_MIN_HZ = 25_600;
  localparam int unsigned PWM_CLK_MAX_HZ = 102_400;
  // fail at half the lowest or twice the highest rate, leaving margin for tolerance
  localparam int unsigned GAP_MAX_CYC   = SYS_CLK_HZ / (PWM_CLK_MIN_HZ / 2);
  localparam int unsigned GAP_MIN_CYC   = (SYS_CLK_HZ + 2 * PWM_CLK_MAX_HZ - 1) / (2 * PWM_CLK_MAX_HZ);
  localparam int unsigned GAP_W         = 13;
endpackage : pwm_pkg
`default_nettype wire

// >>> design/pwm_ctrl_if.sv
// interface: control from the frame decoder and clock supervision to one pwm channel
`default_nettype none
interface pwm_ctrl_if;
  logic [7:0] duty;       // programmed duty value
  logic       on;         // programmed channel on
  logic [1:0] phase;      // phase select
  logic [1:0] prescale;   // prescale select
  logic       tick;       // one pulse per external clock rising edge while no clock failure is flagged
  logic       apply;      // one pulse when a frame commits
  logic       hold_full;  // clock failed or fail mode
  modport ctrl (output duty, on, phase, prescale, tick, apply, hold_full);
  modport chan (input  duty, on, phase, prescale, tick, apply, hold_full);
endinterface : pwm_ctrl_if
`default_nettype wire

// >>> design/pwm_channel.sv
// module: one pwm channel with divider, period counter and duty regulation
`default_nettype none
module pwm_channel
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  pwm_ctrl_if.chan  ctl,
  input  wire logic sense_i,
  output logic      out_o,
  output logic      slew_fast_o
);
  logic [1:0] div_q;
  logic [7:0] cnt_q;
  logic [7:0] duty_act_q;
  logic       on_act_q;
  logic [7:0] meas_q;
  logic [3:0] corr_q;
  logic       out_q;
  logic       slew_q;

  // ---------------------------------------------------------------
  // divided tick and period decode
  // ---------------------------------------------------------------
  wire logic       ch_tick   = ctl.tick & ((ctl.prescale[1])
                                          | (ctl.prescale == pwm_pkg::PRS_DIV2 & div_q[0])
                                          | (ctl.prescale == pwm_pkg::PRS_DIV4 & (&div_q))); // [R10]
  wire logic       wrap      = ch_tick & (&cnt_q);
  wire logic       immediate = ~ctl.on | (ctl.duty == pwm_pkg::DUTY_FULL);              // [R09]
  wire logic [7:0] phased    = cnt_q + {ctl.phase, 6'h00};
  wire logic [8:0] tgt_raw   = {1'b0, duty_act_q} + {{5{corr_q[3]}}, corr_q};
  wire logic [7:0] target    = tgt_raw[8] ? (corr_q[3] ? 8'h00 : pwm_pkg::DUTY_FULL) : tgt_raw[7:0];
  wire logic       corr_up   = (meas_q < duty_act_q) & (corr_q != pwm_pkg::CORR_MAX);
  wire logic       corr_dn   = (meas_q > duty_act_q) & (corr_q != pwm_pkg::CORR_MIN);
  // active while the phased count is below the corrected duty, full duty stays on
  wire logic       pwm_lvl   = on_act_q & ((duty_act_q == pwm_pkg::DUTY_FULL) | (phased < target)); // [R13]

  // prescaler and 8-bit period counter, driven only by the external clock
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q <= 2'h0;
      cnt_q <= 8'h00;
    end
    else
    begin
      if (ctl.tick)
        div_q <= div_q + 2'h1;                                                         // [R01]
      if (ch_tick)
        cnt_q <= cnt_q + 8'h01;                                                        // [R13]
    end
  end

  // active settings: off and full duty at the frame end, others at the period start
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      duty_act_q <= 8'h00;
      on_act_q   <= 1'b0;
    end
    else if ((ctl.apply & immediate) | wrap)                                           // [R09]
    begin
      duty_act_q <= ctl.duty;
      on_act_q   <= ctl.on;
    end
  end

  // closed loop: count sensed on-ticks per period, nudge the compare value
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meas_q <= 8'h00;
      corr_q <= 4'h0;
    end
    else if (wrap)
    begin
      meas_q <= 8'h00;
      if (!on_act_q || duty_act_q == pwm_pkg::DUTY_FULL)
        corr_q <= 4'h0;
      else if (corr_up)
        corr_q <= corr_q + 4'h1;                                                       // [R08]
      else if (corr_dn)
        corr_q <= corr_q - 4'h1;                                                       // [R07]
    end
    else if (ch_tick && sense_i && meas_q != 8'hFF)
      meas_q <= meas_q + 8'h01;
  end

  // registered output; a failed clock or fail mode holds the output at the programmed on bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_q  <= 1'b0;
      slew_q <= 1'b0;
    end
    else
    begin
      out_q  <= ctl.hold_full ? ctl.on : pwm_lvl;                                      // [R02] [R12]
      slew_q <= ctl.prescale[1];                                                       // [R05]
    end
  end

  assign out_o       = out_q;
  assign slew_fast_o = slew_q;
endmodule : pwm_channel
`default_nettype wire

// >>> bench/host_serial_model.sv
// host side serial master that sends channel control words
`default_nettype none
module host_serial_model
(
  input  wire logic clk_i,
  output logic      frame_select_low_o,
  output logic      sclk_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // idle levels and frame sender
  // ------------------------------------------------------------
  // select line has a pull-up, so it idles high
  initial
  begin
    frame_select_low_o = 1'b1;
    sclk_o             = 1'b0;
    si_o               = 1'b0;
  end
  // msb first, bit taken on falling sclk; short frames only for refusal cases
  task automatic send(input logic [15:0] word, input int nbits);
    int i;
    begin
      @(negedge clk_i);
      frame_select_low_o = 1'b0;
      repeat (16) @(negedge clk_i);  // lead time before first sclk
      for (i = 15; i > 15 - nbits; i--)
      begin
        si_o   = word[i];
        sclk_o = 1'b1;
        repeat (8) @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (8) @(negedge clk_i);
      end
      frame_select_low_o = 1'b1;
      si_o               = ~si_o;    // released line must not echo the last bit
      repeat (48) @(negedge clk_i);  // select high above 1 us between frames
    end
  endtask : send
endmodule : host_serial_model
`default_nettype wire

// >>> bench/channel_pwm_control_assertions.sv
// checker: port-level assertions for the pwm block
`default_nettype none
module channel_pwm_control_assertions
#(
  parameter int unsigned CHANNELS    = 4,
  parameter int unsigned GAP_MAX_CYC = 3125,
  parameter int unsigned GAP_MIN_CYC = 196
)
(
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                frame_select_low_i,
  input wire logic                pwm_clk_i,
  input wire logic                fail_mode_i,
  input wire logic [CHANNELS-1:0] power_output_o,
  input wire logic [CHANNELS-1:0] slew_fast_o,
  input wire logic                clock_fail_o,
  input wire logic                keepalive_bit_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic        pwm_q;
  logic [15:0] gap_q;
  logic [7:0]  sel_q;
  wire logic   hold_w = clock_fail_o | fail_mode_i;
  // cycles since last clock pin rise and since select went high; pins are raw, so margins apply
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwm_q <= 1'b0;
      gap_q <= '0;
      sel_q <= '0;
    end
    else
    begin
      pwm_q <= pwm_clk_i;
      gap_q <= (pwm_clk_i && !pwm_q) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
      sel_q <= !frame_select_low_i ? 8'h00 : sel_q + {7'h00, sel_q != 8'hFF};
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_values: assert property (disable iff (1'b0) rst_i |-> power_output_o == '0 && slew_fast_o == '0
    && clock_fail_o && !keepalive_bit_o) else $error("outputs not at reset values");
  a_gap_fail: assert property (gap_q > GAP_MAX_CYC + 8 |-> clock_fail_o)
    else $error("clock fail not raised after a long gap");
  a_fail_cause: assert property ($rose(clock_fail_o) |-> gap_q + 4 >= GAP_MAX_CYC || gap_q <= 8)
    else $error("clock fail raised without cause");
  a_fail_clear: assert property ($fell(clock_fail_o) |-> gap_q <= 8)
    else $error("clock fail cleared away from a clock edge");
  a_slew_commit: assert property (!$stable(slew_fast_o) |-> sel_q >= 2 && sel_q <= 12)
    else $error("slew select changed outside a commit");
  a_keep_commit: assert property (!$stable(keepalive_bit_o) |-> sel_q >= 2 && sel_q <= 12)
    else $error("keepalive changed outside a commit");
  a_out_cause: assert property (!$stable(power_output_o) && !hold_w && !$past(hold_w) && !$past(hold_w, 2)
    |-> gap_q <= 10 || (sel_q >= 2 && sel_q <= 12)) else $error("output moved without tick or commit");
  a_hold_steady: assert property (hold_w && $past(hold_w) && $past(hold_w, 2) && sel_q > 12
    |=> $stable(power_output_o)) else $error("output moved while pwm is suspended");
endmodule : channel_pwm_control_assertions
bind channel_pwm_control channel_pwm_control_assertions
#(.CHANNELS(CHANNELS), .GAP_MAX_CYC(GAP_MAX_CYC), .GAP_MIN_CYC(GAP_MIN_CYC)) u_checker
(.clk_i(clk_i), .rst_i(rst_i), .frame_select_low_i(frame_select_low_i), .pwm_clk_i(pwm_clk_i),
 .fail_mode_i(fail_mode_i), .power_output_o(power_output_o), .slew_fast_o(slew_fast_o),
 .clock_fail_o(clock_fail_o), .keepalive_bit_o(keepalive_bit_o));
`default_nettype wire

// >>> bench/channel_pwm_control_tb.sv
// testbench: self-checking scenarios for the per-channel pwm block
`default_nettype none
module channel_pwm_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned GAP_MAX = 200;  // shortened supervision gap for simulation
  logic       clk_i       = 1'b0;
  logic       rst_i       = 1'b0;  // raised at time zero so the asynchronous reset sees an edge
  logic       pwm_clk     = 1'b0;
  logic       pwm_run     = 1'b0;
  logic       fail_mode   = 1'b0;
  wire logic  sel_n;
  wire logic  sclk;
  wire logic  si;
  logic [3:0] power_output_o;
  logic [3:0] slew_fast;
  logic       clock_fail;
  logic       keepalive;
  wire logic [3:0] sense = power_output_o;  // ideal feedback, so regulation should settle
  int         errors      = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  int         n;
  // ------------------------------------------------------------
  // clocks, timeout and instances
  // ------------------------------------------------------------
  always #12.5 clk_i = ~clk_i;
  // external pwm clock, 40 system cycles a period; stands still when stopped
  always
  begin
    repeat (20) @(negedge clk_i);
    if (pwm_run)
      pwm_clk = ~pwm_clk;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      errors++;
      finish_test();
    end
  end
  host_serial_model u_host (.clk_i(clk_i), .frame_select_low_o(sel_n), .sclk_o(sclk), .si_o(si));
  channel_pwm_control #(.CHANNELS(4), .GAP_MAX_CYC(GAP_MAX), .GAP_MIN_CYC(10)) uut
  (.clk_i(clk_i), .rst_i(rst_i), .frame_select_low_i(sel_n), .sclk_i(sclk), .si_i(si), .pwm_clk_i(pwm_clk),
   .fail_mode_i(fail_mode), .sense_i(sense), .power_output_o(power_output_o), .slew_fast_o(slew_fast),
   .clock_fail_o(clock_fail), .keepalive_bit_o(keepalive));
  // ------------------------------------------------------------
  // compare, measure and closing tasks
  // ------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        errors++;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk_val
  task automatic chk_near(input int got, input int exp, input int tol);
    begin
      comparisons++;
      if (got < exp - tol || got > exp + tol)
      begin
        errors++;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk_near
  // counts external clock rises during one whole high pulse of a channel
  task automatic pulse_ticks(input int ch, output int cnt);
    logic p;
    begin
      cnt = 0;
      while (power_output_o[ch] !== 1'b0) @(negedge clk_i);
      while (power_output_o[ch] !== 1'b1) @(negedge clk_i);
      p = pwm_clk;
      while (power_output_o[ch] === 1'b1)
      begin
        @(negedge clk_i);
        if (pwm_clk && !p)
          cnt++;
        p = pwm_clk;
      end
    end
  endtask : pulse_ticks
  task automatic finish_test();
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : finish_test
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    chk_val(power_output_o, 4'h0);
    chk_val(clock_fail, 1'b1);
    chk_val(keepalive, 1'b0);
    pwm_run = 1'b1;
    repeat (800) @(negedge clk_i);
    chk_val(clock_fail, 1'b0);
    // ch0 divide by 1, ch1 divide by 2; ch0 on at half duty with keepalive set
    u_host.send(16'hC006, 16);
    u_host.send(16'h2980, 16);
    chk_val(keepalive, 1'b1);
    chk_val(slew_fast, 4'h1);
    u_host.send(16'h2000, 15);  // short frame must be dropped
    chk_val(keepalive, 1'b1);
    pulse_ticks(0, n);
    chk_near(n, 128, 1);
    for (int i = 2; i < 6; i++)
      u_host.send({i[3:0], 12'h1FF}, 16);
    chk_val(power_output_o, 4'hF);
    u_host.send(16'h8000, 16);
    chk_val(power_output_o, 4'h0);
    u_host.send(16'h8005, 16);
    chk_val(power_output_o, 4'h5);
    u_host.send(16'h3108, 16);  // lowest usable duty for divide by 2
    pulse_ticks(1, n);
    chk_near(n, 16, 2);
    // clock loss: outputs that are on go to full duty and stay there
    pwm_run = 1'b0;
    repeat (GAP_MAX + 20) @(negedge clk_i);
    chk_val(clock_fail, 1'b1);
    chk_val(power_output_o, 4'h7);
    repeat (600) @(negedge clk_i);
    chk_val(power_output_o, 4'h7);
    pwm_run = 1'b1;
    repeat (400) @(negedge clk_i);
    chk_val(clock_fail, 1'b0);
    fail_mode = 1'b1;
    repeat (10) @(negedge clk_i);
    chk_val(power_output_o, 4'h7);
    repeat (600) @(negedge clk_i);
    chk_val(power_output_o, 4'h7);
    fail_mode = 1'b0;
    finish_test();
  end
endmodule : channel_pwm_control_tb
`default_nettype wire
